/* hdl/bsfe_boot_flash.sv */
`timescale 1ns/100ps
`include "bsfe_cfg.svh"

module bsfe_boot_flash (
  input wire logic clk,
  input wire logic resetn,
  input wire logic prog_entry_pin,
  input wire logic cpu_req,
  input wire logic cpu_write,
  input wire logic [31:0] cpu_addr,
  input wire logic [31:0] cpu_wdata,
  output logic cpu_ack,
  output logic cpu_err,
  output logic [31:0] cpu_rdata,
  input wire logic erase_req,
  input wire logic erase_page_mode,
  input wire logic [7:0] erase_num,
  output logic erase_busy,
  input wire logic rom_load_en,
  input wire logic [10:0] rom_load_addr,
  input wire logic [31:0] rom_load_data,
  output logic boot_done,
  output logic serial_programming_mode,
  output logic user_code_valid,
  output logic alias_on
);

  // ----------------------------------------
  // Error code and reserved page helpers
  // ----------------------------------------

  // Hamming code over positions 1..38; check bits sit at powers of two.
  function automatic logic [5:0] ecc_gen(input logic [31:0] d);
    logic [5:0] p;
    int k;
    p = 6'h00;
    k = 0;
    for (int pos = 1; pos <= `BSFE_ECC_POSITIONS; pos++)
    begin
      if ((pos & (pos - 1)) != 0)
      begin
        for (int j = 0; j < 6; j++)
        begin
          if (pos[j])
            p[j] = p[j] ^ d[k];
        end
        k++;
      end
    end
    return p;
  endfunction : ecc_gen

  // A syndrome pointing at a data position flips that bit; any other
  // syndrome leaves the word as fetched, so a check-bit error or a pattern
  // beyond the code's reach returns the raw word.
  function automatic logic [31:0] ecc_fix(input logic [31:0] d, input logic [5:0] code);
    logic [5:0] syn;
    logic [31:0] r;
    int k;
    syn = code ^ ecc_gen(d);
    r = d;
    k = 0;
    for (int pos = 1; pos <= `BSFE_ECC_POSITIONS; pos++)
    begin
      if ((pos & (pos - 1)) != 0)
      begin
        if (syn == 6'(pos))
          r[k] = ~d[k];
        k++;
      end
    end
    return r;
  endfunction : ecc_fix

  // Flash word lies in the boot block pages at the top of sector 15.
  function automatic logic is_reserved(input logic [11:0] idx);
    return idx[11:4] >= `BSFE_BOOT_PAGE_FIRST;
  endfunction : is_reserved

  // ----------------------------------------
  // Storage
  // ----------------------------------------

  // The code array has no address decode of its own: only the encoder and
  // the corrector ever touch it.
  logic [31:0] flash_mem [0:`BSFE_FLASH_WORDS-1];
  logic [5:0] ecc_mem [0:`BSFE_FLASH_WORDS-1];
  logic [31:0] rom_mem [0:`BSFE_ROM_WORDS-1];

  bsfe_pkg::bsfe_state_type state;
  bsfe_pkg::bsfe_region_type region;
  bsfe_pkg::bsfe_region_type pend_region;
  logic pin_low;
  logic [2:0] chk_cnt;
  logic [31:0] chk_sum;
  logic chk_nonzero;
  logic pend;
  logic pend_write;
  logic [31:0] raw_q;
  logic [5:0] ecc_q;
  logic [31:0] rom_q;
  logic [31:0] fixed;
  logic [11:0] rd_idx;
  logic [10:0] rom_idx;
  logic [11:0] er_idx;
  logic [8:0] er_left;
  logic cpu_take;
  logic erase_take;
  logic erase_refused;

  // ----------------------------------------
  // Access decode
  // ----------------------------------------

  // The alias window wins over flash while the boot vectors are mapped low.
  always_comb
  begin
    region = bsfe_pkg::RG_BAD;
    rom_idx = cpu_addr[12:2];
    if (alias_on && cpu_addr < `BSFE_ALIAS_BYTES)
    begin
      region = bsfe_pkg::RG_ROM;
      rom_idx = {4'h0, cpu_addr[8:2]};
    end
    else if (cpu_addr < `BSFE_FLASH_BYTES && !is_reserved(cpu_addr[13:2]))
      region = bsfe_pkg::RG_FLASH;
    else if (cpu_addr >= `BSFE_ROM_BASE && cpu_addr < `BSFE_ROM_BASE + `BSFE_ROM_BYTES)
      region = bsfe_pkg::RG_ROM;
    if (cpu_write && region == bsfe_pkg::RG_ROM)
      region = bsfe_pkg::RG_BAD;
  end

  // Erase of a reserved page is refused outright.
  assign erase_refused = erase_page_mode && erase_num >= `BSFE_BOOT_PAGE_FIRST;
  assign erase_take = erase_req && boot_done && !erase_busy && !pend && !erase_refused;
  // Processor waits until the boot decision is over and no erase runs.
  assign cpu_take = cpu_req && boot_done && !erase_busy && !pend && !cpu_ack && !erase_take;

  // Boot sequence owns the read port until it is done.
  always_comb
  begin
    case (state)
      bsfe_pkg::ST_CRP_RD: rd_idx = `BSFE_ENTRY_LOCK_INDEX;
      bsfe_pkg::ST_SUM_RD: rd_idx = {9'h000, chk_cnt};
      default: rd_idx = cpu_addr[13:2];
    endcase
  end

  assign fixed = ecc_fix(raw_q, ecc_q);

  // ----------------------------------------
  // Array reads
  // ----------------------------------------

  // Raw word and its code are fetched together every cycle.
  always_ff @(posedge clk)
  begin
    raw_q <= flash_mem[rd_idx];
    ecc_q <= ecc_mem[rd_idx];
    rom_q <= rom_mem[rom_idx];
  end

  // ----------------------------------------
  // Array writes
  // ----------------------------------------

  // Erase and processor writes never meet: the take terms exclude each
  // other, so one write port is enough. A plain clocked process, so a bench may preload the arrays.
  always @(posedge clk)
  begin
    if (erase_busy && !is_reserved(er_idx))
    begin
      flash_mem[er_idx] <= `BSFE_ERASED_WORD;
      ecc_mem[er_idx] <= ecc_gen(`BSFE_ERASED_WORD);
    end
    else if (cpu_take && cpu_write && region == bsfe_pkg::RG_FLASH)
    begin
      flash_mem[cpu_addr[13:2]] <= cpu_wdata;
      ecc_mem[cpu_addr[13:2]] <= ecc_gen(cpu_wdata);
    end
  end

  // Boot ROM image is loaded from the production port only.
  always_ff @(posedge clk)
  begin
    if (rom_load_en)
      rom_mem[rom_load_addr] <= rom_load_data;
  end

  // ----------------------------------------
  // Erase engine
  // ----------------------------------------

  // One word per cycle; a sector walks 256 words, a page 16.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      erase_busy <= 1'b0;
      er_idx <= 12'h000;
      er_left <= 9'h000;
    end
    else if (erase_take)
    begin
      erase_busy <= 1'b1;
      if (erase_page_mode)
      begin
        er_idx <= {erase_num, 4'h0};
        er_left <= `BSFE_PAGE_WORDS;
      end
      else
      begin
        er_idx <= {erase_num[3:0], 8'h00};
        er_left <= `BSFE_SECTOR_WORDS;
      end
    end
    else if (erase_busy)
    begin
      er_idx <= er_idx + 12'h001;
      er_left <= er_left - 9'h001;
      if (er_left == 9'h001)
        erase_busy <= 1'b0;
    end
  end

  // ----------------------------------------
  // Processor answer
  // ----------------------------------------

  // Taken at one edge, answered one edge later, so the answer sees the
  // fetched word after it has settled in the read registers.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pend <= 1'b0;
      pend_write <= 1'b0;
      pend_region <= bsfe_pkg::RG_BAD;
      cpu_ack <= 1'b0;
      cpu_err <= 1'b0;
      cpu_rdata <= 32'h0000_0000;
    end
    else
    begin
      pend <= cpu_take;
      if (cpu_take)
      begin
        pend_write <= cpu_write;
        pend_region <= region;
      end
      cpu_ack <= pend;
      cpu_err <= pend && pend_region == bsfe_pkg::RG_BAD;
      cpu_rdata <= 32'h0000_0000;
      if (pend && !pend_write)
      begin
        case (pend_region)
          bsfe_pkg::RG_FLASH: cpu_rdata <= fixed;
          bsfe_pkg::RG_ROM: cpu_rdata <= rom_q;
          default: cpu_rdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Boot decision
  // ----------------------------------------

  // Runs from every reset release; the pin is caught by a clocked step after
  // release and then never looked at again.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state <= bsfe_pkg::ST_PIN;
      pin_low <= 1'b0;
      chk_cnt <= 3'h0;
      chk_sum <= 32'h0000_0000;
      chk_nonzero <= 1'b0;
      boot_done <= 1'b0;
      serial_programming_mode <= 1'b0;
      user_code_valid <= 1'b0;
      alias_on <= 1'b1;
    end
    else
    begin
      case (state)
        bsfe_pkg::ST_PIN:
        begin
          pin_low <= !prog_entry_pin;
          state <= bsfe_pkg::ST_CRP_RD;
        end
        bsfe_pkg::ST_CRP_RD:
          state <= bsfe_pkg::ST_CRP_CHK;
        bsfe_pkg::ST_CRP_CHK:
        begin
          chk_cnt <= 3'h0;
          chk_sum <= 32'h0000_0000;
          chk_nonzero <= 1'b0;
          // A programmed pattern makes the pin a don't-care.
          if (pin_low && fixed != `BSFE_ENTRY_LOCK_WORD)
            state <= bsfe_pkg::ST_PROG;
          else
            state <= bsfe_pkg::ST_SUM_RD;
        end
        bsfe_pkg::ST_SUM_RD:
          state <= bsfe_pkg::ST_SUM_ACC;
        bsfe_pkg::ST_SUM_ACC:
        begin
          chk_sum <= chk_sum + fixed;
          chk_nonzero <= chk_nonzero || fixed != 32'h0000_0000;
          if (chk_cnt == `BSFE_CHECK_LAST)
            state <= bsfe_pkg::ST_DECIDE;
          else
          begin
            chk_cnt <= chk_cnt + 3'h1;
            state <= bsfe_pkg::ST_SUM_RD;
          end
        end
        bsfe_pkg::ST_DECIDE:
        begin
          boot_done <= 1'b1;
          // Entry seven balances the sum; an all-zero table does not count.
          if (chk_sum == 32'h0000_0000 && chk_nonzero)
          begin
            user_code_valid <= 1'b1;
            alias_on <= 1'b0;
            state <= bsfe_pkg::ST_USER;
          end
          else
          begin
            serial_programming_mode <= 1'b1;
            state <= bsfe_pkg::ST_PROG;
          end
        end
        bsfe_pkg::ST_USER:
          state <= bsfe_pkg::ST_USER;
        bsfe_pkg::ST_PROG:
        begin
          boot_done <= 1'b1;
          serial_programming_mode <= 1'b1;
          state <= bsfe_pkg::ST_PROG;
        end
        default:
          state <= bsfe_pkg::ST_PIN;
      endcase
    end
  end

endmodule : bsfe_boot_flash

/* hdl/bsfe_cfg.svh */
`ifndef BSFE_CFG_SVH
`define BSFE_CFG_SVH


// ----------------------------------------
// Address map
// ----------------------------------------
`define BSFE_FLASH_BYTES 32'h0000_4000
`define BSFE_ROM_BASE 32'h0f00_0000
`define BSFE_ROM_BYTES 32'h0000_2000
`define BSFE_ALIAS_BYTES 32'h0000_0200
`define BSFE_FLASH_WORDS 4096
`define BSFE_ROM_WORDS 2048

// ----------------------------------------
// Partitioning
// ----------------------------------------
`define BSFE_SECTOR_WORDS 9'h100
`define BSFE_PAGE_WORDS 9'h010
`define BSFE_BOOT_PAGE_FIRST 8'hfe

// ----------------------------------------
// Boot check and erase values
// ----------------------------------------
`define BSFE_ENTRY_LOCK_INDEX 12'h0bf
`define BSFE_ENTRY_LOCK_WORD 32'h4e69_7370
`define BSFE_CHECK_LAST 3'h7
`define BSFE_ERASED_WORD 32'hffff_ffff
`define BSFE_ECC_POSITIONS 38

`endif

/* hdl/bsfe_pkg.sv */
package bsfe_pkg;

  // Boot decision sequence states.
  typedef enum logic [2:0] {
    ST_PIN,
    ST_CRP_RD,
    ST_CRP_CHK,
    ST_SUM_RD,
    ST_SUM_ACC,
    ST_DECIDE,
    ST_USER,
    ST_PROG
  } bsfe_state_type;

  // Target of a processor access.
  typedef enum logic [1:0] {
    RG_FLASH,
    RG_ROM,
    RG_BAD
  } bsfe_region_type;

endpackage : bsfe_pkg

/* testbench/bsfe_boot_flash_assertions.sv */
`timescale 1ns/100ps
module bsfe_boot_flash_assertions (
  input wire logic clk,
  input wire logic resetn,
  input wire logic cpu_req,
  input wire logic cpu_ack,
  input wire logic cpu_err,
  input wire logic [31:0] cpu_rdata,
  input wire logic erase_req,
  input wire logic erase_page_mode,
  input wire logic [7:0] erase_num,
  input wire logic erase_busy,
  input wire logic boot_done,
  input wire logic serial_programming_mode,
  input wire logic user_code_valid,
  input wire logic alias_on
);
  // All checks share one clock and are quiet while reset is low.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence s_take;
    $rose(cpu_req) && boot_done && !erase_busy && !erase_req && !cpu_ack;
  endsequence
  sequence s_page;
    erase_req && erase_page_mode && erase_num < 8'hfe && boot_done && !erase_busy && !cpu_req;
  endsequence
  property p_ack_two; s_take |-> !cpu_ack ##1 !cpu_ack ##1 cpu_ack; endproperty
  a_ack_two: assert property (p_ack_two) else $error("answer not two cycles after request");
  property p_ack_pulse; cpu_ack |=> !cpu_ack; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("answer longer than one cycle");
  property p_quiet; !cpu_ack |-> cpu_rdata == 32'h0 && !cpu_err; endproperty
  a_quiet: assert property (p_quiet) else $error("data outside answer cycle");
  property p_pre_boot; !boot_done |-> !cpu_ack && !serial_programming_mode && !user_code_valid && alias_on; endproperty
  a_pre_boot: assert property (p_pre_boot) else $error("activity before boot decision");
  property p_one_mode; boot_done |-> serial_programming_mode != user_code_valid; endproperty
  a_one_mode: assert property (p_one_mode) else $error("boot outcome not exclusive");
  property p_alias; boot_done |-> alias_on == serial_programming_mode; endproperty
  a_alias: assert property (p_alias) else $error("alias state wrong");
  property p_hold; boot_done |=> boot_done && $stable(user_code_valid); endproperty
  a_hold: assert property (p_hold) else $error("boot outcome changed");
  property p_page_len; s_page |=> erase_busy[*8] ##1 erase_busy[*8] ##1 !erase_busy; endproperty
  a_page_len: assert property (p_page_len) else $error("page erase length wrong");
  property p_reserved; erase_req && erase_page_mode && erase_num >= 8'hfe && !erase_busy |=> !erase_busy; endproperty
  a_reserved: assert property (p_reserved) else $error("reserved page erase taken");
endmodule : bsfe_boot_flash_assertions

/* testbench/bsfe_cpu_model.sv */
`timescale 1ns/100ps
module bsfe_cpu_model (
  input wire logic clk,
  input wire logic cpu_ack,
  input wire logic cpu_err,
  input wire logic [31:0] cpu_rdata,
  output logic cpu_req,
  output logic cpu_write,
  output logic [31:0] cpu_addr,
  output logic [31:0] cpu_wdata
);
  initial
  begin
    cpu_req = 1'b0;
    cpu_write = 1'b0;
    cpu_addr = 32'h0;
    cpu_wdata = 32'h0;
  end
  // One word access; held through the edge that samples the answer, then idle lines are inverted.
  task access(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd, output logic er);
    int n;
    @(negedge clk);
    cpu_req = 1'b1;
    cpu_write = wr;
    cpu_addr = a;
    cpu_wdata = wd;
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
    end
    while (cpu_ack !== 1'b1 && n < 100);
    rd = cpu_rdata;
    // A missing answer returns an unknown error flag, so the caller's compare trips.
    er = (cpu_ack === 1'b1) ? cpu_err : 1'bx;
    @(negedge clk);
    cpu_req = 1'b0;
    cpu_write = ~wr;
    cpu_addr = ~a;
    cpu_wdata = ~wd;
  endtask : access
endmodule : bsfe_cpu_model

/* testbench/tb_boot_select_flash_ecc.sv */
`timescale 1ns/100ps
module tb_boot_select_flash_ecc;
  logic clk, resetn, prog_entry_pin, cpu_req, cpu_write, cpu_ack, cpu_err;
  logic [31:0] cpu_addr, cpu_wdata, cpu_rdata, rom_load_data;
  logic erase_req, erase_page_mode, erase_busy, rom_load_en;
  logic [7:0] erase_num;
  logic [10:0] rom_load_addr;
  logic boot_done, serial_programming_mode, user_code_valid, alias_on;
  int err_total = 0;
  int comparisons = 0;
  bsfe_boot_flash uut (.clk(clk), .resetn(resetn), .prog_entry_pin(prog_entry_pin), .cpu_req(cpu_req),
    .cpu_write(cpu_write), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_ack(cpu_ack), .cpu_err(cpu_err),
    .cpu_rdata(cpu_rdata), .erase_req(erase_req), .erase_page_mode(erase_page_mode), .erase_num(erase_num),
    .erase_busy(erase_busy), .rom_load_en(rom_load_en), .rom_load_addr(rom_load_addr),
    .rom_load_data(rom_load_data), .boot_done(boot_done), .serial_programming_mode(serial_programming_mode),
    .user_code_valid(user_code_valid), .alias_on(alias_on));
  bsfe_cpu_model cpu (.clk(clk), .cpu_ack(cpu_ack), .cpu_err(cpu_err), .cpu_rdata(cpu_rdata), .cpu_req(cpu_req),
    .cpu_write(cpu_write), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata));
  // Clock at 50 MHz.
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task acc(input logic wr, input logic [31:0] a, input logic [31:0] d, input logic [31:0] exp, input logic er);
    logic [31:0] r;
    logic e;
    cpu.access(wr, a, d, r, e);
    check(r, exp);
    check({31'h0, e}, {31'h0, er});
  endtask : acc
  // Outcome flags packed as programming, user, alias.
  task mode(input logic [2:0] exp);
    check({29'h0, serial_programming_mode, user_code_valid, alias_on}, {29'h0, exp});
  endtask : mode
  task boot(input logic pin);
    int n;
    @(negedge clk);
    resetn = 1'b0;
    prog_entry_pin = pin;
    repeat (20) @(negedge clk);
    resetn = 1'b1;
    @(negedge clk);
    // The pin was taken at the first edge; flipping it now must not matter.
    prog_entry_pin = ~pin;
    n = 0;
    while (boot_done !== 1'b1 && n < 100)
    begin
      @(negedge clk);
      n++;
    end
  endtask : boot
  // Counts busy cycles; a refused request must give zero.
  task erase(input logic pm, input logic [7:0] num, input int len);
    int n;
    @(negedge clk);
    erase_req = 1'b1;
    erase_page_mode = pm;
    erase_num = num;
    @(negedge clk);
    erase_req = 1'b0;
    n = 0;
    while (erase_busy === 1'b1 && n < 400)
    begin
      @(negedge clk);
      n++;
    end
    check(n, len);
  endtask : erase
  // Backdoor into the array; the code is stored as given, not generated from the word.
  task put(input int i, input logic [31:0] d, input logic [5:0] e);
    uut.flash_mem[i] = d;
    uut.ecc_mem[i] = e;
  endtask : put
  task stop_test;
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : stop_test
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_rom;
    boot(1'b0);
    mode(3'b101);
    @(negedge clk);
    rom_load_en = 1'b1;
    rom_load_data = 32'h1234_abcd;
    @(negedge clk);
    rom_load_addr = 11'h7ff;
    rom_load_data = 32'h55aa_0f0f;
    @(negedge clk);
    rom_load_en = 1'b0;
    acc(1'b0, 32'h0f00_0000, 32'h0, 32'h1234_abcd, 1'b0);
    acc(1'b0, 32'h0f00_1ffc, 32'h0, 32'h55aa_0f0f, 1'b0);
    acc(1'b0, 32'h0f00_2000, 32'h0, 32'h0, 1'b1);
    acc(1'b0, 32'h0000_0000, 32'h0, 32'h1234_abcd, 1'b0);
    acc(1'b1, 32'h0000_0000, 32'h1, 32'h0, 1'b1);
    $display("rom and alias test done");
  endtask : t_rom
  task t_erase;
    acc(1'b1, 32'h0000_0400, 32'h0bad_cafe, 32'h0, 1'b0);
    acc(1'b1, 32'h0000_03fc, 32'h7777_1111, 32'h0, 1'b0);
    acc(1'b0, 32'h0000_3f80, 32'h0, 32'h0, 1'b1);
    erase(1'b0, 8'h00, 256);
    acc(1'b0, 32'h0000_03fc, 32'h0, 32'hffff_ffff, 1'b0);
    acc(1'b0, 32'h0000_0400, 32'h0, 32'h0bad_cafe, 1'b0);
    acc(1'b1, 32'h0000_0240, 32'h3c3c_0001, 32'h0, 1'b0);
    erase(1'b1, 8'h09, 16);
    acc(1'b0, 32'h0000_0240, 32'h0, 32'hffff_ffff, 1'b0);
    erase(1'b1, 8'hfe, 0);
    erase(1'b1, 8'hff, 0);
    boot(1'b1);
    mode(3'b101);
    $display("erase test done");
  endtask : t_erase
  task t_valid;
    put(0, 32'h1, 6'h03);
    for (int i = 1; i < 7; i++) put(i, 32'h0, 6'h00);
    put(32'h80, 32'h1, 6'h00);
    put(32'h81, 32'h1, 6'h30);
    boot(1'b1);
    mode(3'b010);
    acc(1'b0, 32'h0000_0000, 32'h0, 32'h1, 1'b0);
    acc(1'b0, 32'h0000_0200, 32'h0, 32'h0, 1'b0);
    acc(1'b0, 32'h0000_0204, 32'h0, 32'h1, 1'b0);
    acc(1'b1, 32'h0000_02fc, 32'h4e69_7370, 32'h0, 1'b0);
    boot(1'b0);
    mode(3'b010);
    for (int i = 0; i < 8; i++) put(i, 32'h0, 6'h00);
    boot(1'b0);
    mode(3'b101);
    $display("boot check test done");
  endtask : t_valid
  // Main sequence and watchdog.
  initial
  begin
    resetn = 1'b0;
    prog_entry_pin = 1'b1;
    erase_req = 1'b0;
    erase_page_mode = 1'b0;
    erase_num = 8'h0;
    rom_load_en = 1'b0;
    rom_load_addr = 11'h0;
    rom_load_data = 32'h0;
    // Known flash content, so the first boot decision sees no unknowns.
    for (int i = 0; i < 4096; i++) put(i, 32'h0, 6'h00);
    t_rom;
    t_erase;
    t_valid;
    stop_test;
  end
  initial
  begin
    #200000;
    err_total++;
    stop_test;
  end
endmodule : tb_boot_select_flash_ecc
bind bsfe_boot_flash bsfe_boot_flash_assertions chk (.clk(clk), .resetn(resetn), .cpu_req(cpu_req),
  .cpu_ack(cpu_ack), .cpu_err(cpu_err), .cpu_rdata(cpu_rdata), .erase_req(erase_req),
  .erase_page_mode(erase_page_mode), .erase_num(erase_num), .erase_busy(erase_busy), .boot_done(boot_done),
  .serial_programming_mode(serial_programming_mode), .user_code_valid(user_code_valid), .alias_on(alias_on));
